// ==== rtl/jbd_cond_eval.sv ====
`timescale 1ns/1ns
`default_nettype none
module jbd_cond_eval
(
    // Condition and flags
    input wire logic [2:0] cc,
    input wire logic [7:0] flags,
    // Result
    output logic cond_true
);
    always_comb
    begin
        unique case (cc)
            jbd_pkg::CC_NZ: cond_true = !flags[jbd_pkg::F_Z];
            jbd_pkg::CC_Z: cond_true = flags[jbd_pkg::F_Z];
            jbd_pkg::CC_NC: cond_true = !flags[jbd_pkg::F_C];
            jbd_pkg::CC_C: cond_true = flags[jbd_pkg::F_C];
            jbd_pkg::CC_PO: cond_true = !flags[jbd_pkg::F_PV];
            jbd_pkg::CC_PE: cond_true = flags[jbd_pkg::F_PV];
            jbd_pkg::CC_P: cond_true = !flags[jbd_pkg::F_S];
            jbd_pkg::CC_M: cond_true = flags[jbd_pkg::F_S];
        endcase
    end
endmodule // jbd_cond_eval
`default_nettype wire

// ==== rtl/jbd_pkg.sv ====
package jbd_pkg;
    // Opcodes
    localparam logic [7:0] OP_ABS = 8'hc3;
    localparam logic [7:0] OP_ABS_CC_MASK = 8'hc7;
    localparam logic [7:0] OP_ABS_CC = 8'hc2;
    localparam logic [7:0] OP_REL = 8'h18;
    localparam logic [7:0] OP_REL_C = 8'h38;
    localparam logic [7:0] OP_REL_NC = 8'h30;
    localparam logic [7:0] OP_REL_Z = 8'h28;
    localparam logic [7:0] OP_REL_NZ = 8'h20;
    localparam logic [7:0] OP_LOOP = 8'h10;
    localparam logic [7:0] OP_IND = 8'he9;
    localparam logic [7:0] PFX_IX1 = 8'hdd;
    localparam logic [7:0] PFX_IX2 = 8'hfd;
    // Condition field position
    localparam int CC_LSB = 3;
    // Condition codes
    localparam logic [2:0] CC_NZ = 3'h0;
    localparam logic [2:0] CC_Z = 3'h1;
    localparam logic [2:0] CC_NC = 3'h2;
    localparam logic [2:0] CC_C = 3'h3;
    localparam logic [2:0] CC_PO = 3'h4;
    localparam logic [2:0] CC_PE = 3'h5;
    localparam logic [2:0] CC_P = 3'h6;
    localparam logic [2:0] CC_M = 3'h7;
    // Flag bit positions
    localparam int F_C = 0;
    localparam int F_PV = 2;
    localparam int F_Z = 6;
    localparam int F_S = 7;
    // T-state counts
    localparam logic [4:0] T_ABS = 5'h0a;
    localparam logic [4:0] T_REL_NT = 5'h07;
    localparam logic [4:0] T_REL_TK = 5'h0c;
    localparam logic [4:0] T_LOOP_NT = 5'h08;
    localparam logic [4:0] T_LOOP_TK = 5'h0d;
    localparam logic [4:0] T_IND = 5'h04;
    localparam logic [4:0] T_IND_IX = 5'h08;
    // Machine cycle counts
    localparam logic [2:0] M_ONE = 3'h1;
    localparam logic [2:0] M_TWO = 3'h2;
    localparam logic [2:0] M_THREE = 3'h3;
    // Lengths in bytes
    localparam logic [15:0] LEN_ONE = 16'h0001;
    localparam logic [15:0] LEN_TWO = 16'h0002;
    localparam logic [15:0] LEN_THREE = 16'h0003;
    localparam logic [7:0] ONE_B = 8'h01;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] B_RST = 8'h00;
endpackage

// ==== rtl/jbd_top.sv ====
// Behaviour
// - True condition loads two-byte target; 3 bytes, 3 M, 10 T.
// - False condition continues after 3 bytes; eight condition codes.
// - Relative on carry: 7 T fall through, 12 T branch when set.
// - Relative on no carry: branches when carry clear, same counts.
// - Relative on zero: branches when zero set, 12 T; else 7 T.
// - Relative on non-zero: branches when zero clear.
// - Loop decrements counter; zero falls through 8 T, else branch 13 T.
// - Displacement byte plus two, added to opcode address; -126 to +129.
`timescale 1ns/1ns
`default_nettype none
module jbd_top
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Instruction bytes
    input wire logic exec,
    input wire logic [7:0] op0,
    input wire logic [7:0] op1,
    input wire logic [7:0] op2,
    // Register file view
    input wire logic [15:0] pc_in,
    input wire logic [7:0] b_in,
    input wire logic [7:0] flags_in,
    input wire logic [15:0] pointer_pair,
    input wire logic [15:0] first_index_register,
    input wire logic [15:0] second_index_register,
    // Results
    output logic done_ff,
    output logic known_ff,
    output logic taken_ff,
    output logic [15:0] pc_ff,
    output logic [7:0] b_ff,
    output logic [7:0] flags_ff,
    output logic [2:0] mcyc_ff,
    output logic [4:0] tst_ff
);
    logic cond_true;
    logic [7:0] dec_b;
    logic [15:0] rel_tgt;
    logic [15:0] nxt_pc;
    logic [7:0] nxt_b;
    logic [2:0] nxt_mcyc;
    logic [4:0] nxt_tst;
    logic nxt_taken;
    logic nxt_known;

    jbd_cond_eval u_cond
    (
        .cc(op0[jbd_pkg::CC_LSB +: 3]),
        .flags(flags_in),
        .cond_true(cond_true)
    );

    assign dec_b = b_in - jbd_pkg::ONE_B;
    // Offset applies from the byte after the two-byte instruction
    assign rel_tgt = pc_in + jbd_pkg::LEN_TWO
        + {{8{op1[7]}}, op1};

    function automatic logic rel_cond(input logic [7:0] op,
        input logic [7:0] f);
        begin
            rel_cond = 1'b0;
            if (op == jbd_pkg::OP_REL)
                rel_cond = 1'b1;
            else if (op == jbd_pkg::OP_REL_C)
                rel_cond = f[jbd_pkg::F_C];
            else if (op == jbd_pkg::OP_REL_NC)
                rel_cond = !f[jbd_pkg::F_C];
            else if (op == jbd_pkg::OP_REL_Z)
                rel_cond = f[jbd_pkg::F_Z];
            else if (op == jbd_pkg::OP_REL_NZ)
                rel_cond = !f[jbd_pkg::F_Z];
        end
    endfunction

    function automatic logic is_rel(input logic [7:0] op);
        begin
            is_rel = (op == jbd_pkg::OP_REL) || (op == jbd_pkg::OP_REL_C)
                || (op == jbd_pkg::OP_REL_NC) || (op == jbd_pkg::OP_REL_Z)
                || (op == jbd_pkg::OP_REL_NZ);
        end
    endfunction

    // Decode and execute
    always_comb
    begin
        nxt_pc = pc_in;
        nxt_b = b_in;
        nxt_mcyc = jbd_pkg::M_ONE;
        nxt_tst = jbd_pkg::T_IND;
        nxt_taken = 1'b0;
        nxt_known = 1'b1;
        if (op0 == jbd_pkg::OP_ABS)
        begin
            nxt_pc = {op2, op1};
            nxt_taken = 1'b1;
            nxt_mcyc = jbd_pkg::M_THREE;
            nxt_tst = jbd_pkg::T_ABS;
        end
        else if ((op0 & jbd_pkg::OP_ABS_CC_MASK) == jbd_pkg::OP_ABS_CC)
        begin
            nxt_taken = cond_true;
            nxt_pc = cond_true ? {op2, op1}
                : pc_in + jbd_pkg::LEN_THREE;
            nxt_mcyc = jbd_pkg::M_THREE;
            nxt_tst = jbd_pkg::T_ABS;
        end
        else if (is_rel(op0))
        begin
            nxt_taken = rel_cond(op0, flags_in);
            nxt_pc = nxt_taken ? rel_tgt : pc_in + jbd_pkg::LEN_TWO;
            nxt_mcyc = nxt_taken ? jbd_pkg::M_THREE : jbd_pkg::M_TWO;
            nxt_tst = nxt_taken ? jbd_pkg::T_REL_TK
                : jbd_pkg::T_REL_NT;
        end
        else if (op0 == jbd_pkg::OP_LOOP)
        begin
            nxt_b = dec_b;
            nxt_taken = (dec_b != jbd_pkg::B_RST);
            nxt_pc = nxt_taken ? rel_tgt : pc_in + jbd_pkg::LEN_TWO;
            nxt_mcyc = nxt_taken ? jbd_pkg::M_THREE : jbd_pkg::M_TWO;
            nxt_tst = nxt_taken ? jbd_pkg::T_LOOP_TK
                : jbd_pkg::T_LOOP_NT;
        end
        else if (op0 == jbd_pkg::OP_IND)
        begin
            nxt_pc = pointer_pair;
            nxt_taken = 1'b1;
        end
        else if ((op0 == jbd_pkg::PFX_IX1 || op0 == jbd_pkg::PFX_IX2)
            && op1 == jbd_pkg::OP_IND)
        begin
            nxt_pc = (op0 == jbd_pkg::PFX_IX1) ? first_index_register
                : second_index_register;
            nxt_taken = 1'b1;
            nxt_mcyc = jbd_pkg::M_TWO;
            nxt_tst = jbd_pkg::T_IND_IX;
        end
        else
        begin
            nxt_known = 1'b0;
        end
    end

    // Result registers
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            done_ff <= 1'b0;
            known_ff <= 1'b0;
            taken_ff <= 1'b0;
            pc_ff <= jbd_pkg::PC_RST;
            b_ff <= jbd_pkg::B_RST;
            mcyc_ff <= jbd_pkg::M_ONE;
            tst_ff <= jbd_pkg::T_IND;
        end
        else
        begin
            done_ff <= exec;
            if (exec)
            begin
                known_ff <= nxt_known;
                taken_ff <= nxt_taken;
                pc_ff <= nxt_pc;
                b_ff <= nxt_b;
                mcyc_ff <= nxt_mcyc;
                tst_ff <= nxt_tst;
            end
        end
    end

    // Flags pass through untouched
    always_ff @(posedge clk)
    begin
        if (!nrst)
            flags_ff <= jbd_pkg::B_RST;
        else if (exec)
            flags_ff <= flags_in;
    end

    property p_flags_kept;
        @(posedge clk) disable iff (!nrst)
        exec |=> flags_ff == $past(flags_in);
    endproperty
    a_flags_kept: assert property (p_flags_kept)
        else $error("flags changed");

    property p_abs_cc;
        @(posedge clk) disable iff (!nrst)
        exec && (op0 & jbd_pkg::OP_ABS_CC_MASK) == jbd_pkg::OP_ABS_CC
        && cond_true |=> pc_ff == {$past(op2), $past(op1)}
        && tst_ff == jbd_pkg::T_ABS;
    endproperty
    a_abs_cc: assert property (p_abs_cc)
        else $error("cond jump target wrong");

    property p_abs_nt;
        @(posedge clk) disable iff (!nrst)
        exec && (op0 & jbd_pkg::OP_ABS_CC_MASK) == jbd_pkg::OP_ABS_CC
        && !cond_true |=> pc_ff == $past(pc_in) + jbd_pkg::LEN_THREE
        && !taken_ff;
    endproperty
    a_abs_nt: assert property (p_abs_nt)
        else $error("cond jump fallthrough wrong");

    property p_rel_c;
        @(posedge clk) disable iff (!nrst)
        exec && op0 == jbd_pkg::OP_REL_C |=>
        tst_ff == ($past(flags_in[jbd_pkg::F_C]) ? jbd_pkg::T_REL_TK
        : jbd_pkg::T_REL_NT);
    endproperty
    a_rel_c: assert property (p_rel_c)
        else $error("carry branch timing wrong");

    property p_rel_nc;
        @(posedge clk) disable iff (!nrst)
        exec && op0 == jbd_pkg::OP_REL_NC |=>
        taken_ff == !$past(flags_in[jbd_pkg::F_C]);
    endproperty
    a_rel_nc: assert property (p_rel_nc)
        else $error("no carry branch wrong");

    property p_rel_z;
        @(posedge clk) disable iff (!nrst)
        exec && op0 == jbd_pkg::OP_REL_Z |=>
        taken_ff == $past(flags_in[jbd_pkg::F_Z]);
    endproperty
    a_rel_z: assert property (p_rel_z)
        else $error("zero branch wrong");

    property p_rel_nz;
        @(posedge clk) disable iff (!nrst)
        exec && op0 == jbd_pkg::OP_REL_NZ && !flags_in[jbd_pkg::F_Z] |=>
        pc_ff == $past(pc_in) + jbd_pkg::LEN_TWO
        + {{8{$past(op1[7])}}, $past(op1)};
    endproperty
    a_rel_nz: assert property (p_rel_nz)
        else $error("non-zero branch target wrong");

    property p_loop;
        @(posedge clk) disable iff (!nrst)
        exec && op0 == jbd_pkg::OP_LOOP |=>
        b_ff == $past(b_in) - jbd_pkg::ONE_B
        && tst_ff == ((b_ff == jbd_pkg::B_RST) ? jbd_pkg::T_LOOP_NT
        : jbd_pkg::T_LOOP_TK);
    endproperty
    a_loop: assert property (p_loop)
        else $error("loop instruction wrong");

    property p_ind;
        @(posedge clk) disable iff (!nrst)
        exec && op0 == jbd_pkg::OP_IND |=> pc_ff == $past(pointer_pair)
        && tst_ff == jbd_pkg::T_IND;
    endproperty
    a_ind: assert property (p_ind)
        else $error("indirect jump wrong");
endmodule // jbd_top
`default_nettype wire

// ==== test/jbd_prog_mem.sv ====
`timescale 1ns/1ns
`default_nettype none
module jbd_prog_mem
(
    // Fetch address
    input wire logic [15:0] addr,
    // Instruction bytes
    output logic [7:0] byte0,
    output logic [7:0] byte1,
    output logic [7:0] byte2
);
    logic [7:0] mem [0:65535];
    initial
    begin
        for (int i = 0; i < 65536; i++)
            mem[i] = 8'h00;
    end
    // Displacement bytes are loaded already encoded by the bench
    assign byte0 = mem[addr];
    assign byte1 = mem[addr + 16'h0001];
    assign byte2 = mem[addr + 16'h0002];
endmodule // jbd_prog_mem
`default_nettype wire

// ==== test/tb_jump_branch_decode.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_jump_branch_decode;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic exec = 1'b0;
    logic [15:0] pc_in = 16'h0000;
    logic [7:0] b_in = 8'h00;
    logic [7:0] flags_in = 8'h00;
    logic [15:0] ptr = 16'h1234;
    logic [15:0] ix1 = 16'h5678;
    logic [15:0] ix2 = 16'h9abc;
    logic [7:0] op0, op1, op2, b_ff, flags_ff;
    logic done_ff, known_ff, taken_ff;
    logic [15:0] pc_ff;
    logic [2:0] mcyc_ff;
    logic [4:0] tst_ff;
    int err_total = 0;
    int comparisons = 0;
    always #2 clk = ~clk;
    jbd_prog_mem pm (.addr(pc_in), .byte0(op0), .byte1(op1), .byte2(op2));
    jbd_top uut (.clk(clk), .nrst(nrst), .exec(exec), .op0(op0), .op1(op1),
        .op2(op2), .pc_in(pc_in), .b_in(b_in), .flags_in(flags_in),
        .pointer_pair(ptr), .first_index_register(ix1),
        .second_index_register(ix2), .done_ff(done_ff), .known_ff(known_ff),
        .taken_ff(taken_ff), .pc_ff(pc_ff), .b_ff(b_ff), .flags_ff(flags_ff),
        .mcyc_ff(mcyc_ff), .tst_ff(tst_ff));
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic put(input logic [15:0] a, input logic [7:0] b0,
        input logic [7:0] b1, input logic [7:0] b2);
        pm.mem[a] = b0;
        pm.mem[a + 16'h0001] = b1;
        pm.mem[a + 16'h0002] = b2;
    endtask
    // One instruction, then check every result
    task automatic exe(input logic [15:0] pc, input logic [7:0] b,
        input logic [7:0] f, input logic k, input logic tk,
        input logic [15:0] npc, input logic [7:0] nb, input logic [2:0] m,
        input logic [4:0] t);
        @(posedge clk);
        exec <= 1'b1;
        pc_in <= pc;
        b_in <= b;
        flags_in <= f;
        @(posedge clk);
        exec <= 1'b0;
        #1;
        chk(16'(done_ff), 16'h0001);
        chk(16'(known_ff), 16'(k));
        chk(16'(taken_ff), 16'(tk));
        chk(pc_ff, npc);
        chk(16'(b_ff), 16'(nb));
        chk(16'(flags_ff), 16'(f));
        chk(16'(mcyc_ff), 16'(m));
        chk(16'(tst_ff), 16'(t));
        // Done lasts one cycle, results stand until the next execute
        @(posedge clk);
        #1;
        chk(16'(done_ff), 16'h0000);
        chk(pc_ff, npc);
    endtask
    // Every output at its reset value
    task automatic chk_rst();
        chk(16'(done_ff), 16'h0000);
        chk(16'(known_ff), 16'h0000);
        chk(16'(taken_ff), 16'h0000);
        chk(pc_ff, jbd_pkg::PC_RST);
        chk(16'(b_ff), 16'(jbd_pkg::B_RST));
        chk(16'(flags_ff), 16'(jbd_pkg::B_RST));
        chk(16'(mcyc_ff), 16'(jbd_pkg::M_ONE));
        chk(16'(tst_ff), 16'(jbd_pkg::T_IND));
    endtask
    task automatic t_reset();
        put(16'h0500, jbd_pkg::OP_ABS, 8'h11, 8'h22);
        exe(16'h0500, 8'h07, 8'h41, 1'b1, 1'b1, 16'h2211, 8'h07,
            jbd_pkg::M_THREE, jbd_pkg::T_ABS);
        // Reset in mid-run beats a pending execute
        @(posedge clk);
        nrst <= 1'b0;
        exec <= 1'b1;
        @(posedge clk);
        nrst <= 1'b1;
        exec <= 1'b0;
        #1;
        chk_rst();
        exe(16'h0500, 8'h07, 8'h41, 1'b1, 1'b1, 16'h2211, 8'h07,
            jbd_pkg::M_THREE, jbd_pkg::T_ABS);
        $display("mid-run reset done");
    endtask
    task automatic t_abs();
        logic [7:0] f;
        logic tk;
        put(16'h0040, jbd_pkg::OP_ABS, 8'h3c, 8'h5a);
        exe(16'h0040, 8'h00, 8'h00, 1'b1, 1'b1, 16'h5a3c, 8'h00,
            jbd_pkg::M_THREE, jbd_pkg::T_ABS);
        for (int i = 0; i < 16; i++)
        begin
            f = i[3] ? 8'hc5 : 8'h00;
            tk = (i[0] == i[3]);
            put(16'h0040, {2'b11, i[2:0], 3'b010}, 8'h3c, 8'h5a);
            exe(16'h0040, 8'h00, f, 1'b1, tk, tk ? 16'h5a3c : 16'h0043,
                8'h00, jbd_pkg::M_THREE, jbd_pkg::T_ABS);
        end
        $display("absolute jumps done");
    endtask
    task automatic t_rel();
        logic [7:0] ops [5];
        logic tk;
        ops = '{jbd_pkg::OP_REL, jbd_pkg::OP_REL_C, jbd_pkg::OP_REL_NC,
            jbd_pkg::OP_REL_Z, jbd_pkg::OP_REL_NZ};
        for (int i = 0; i < 20; i++)
        begin
            tk = (i % 5 == 0) || (i[3] == (i % 5) % 2);
            // Extreme displacements +129 and -126
            put(16'h0080, ops[i % 5], i[4] ? 8'h80 : 8'h7f, 8'h00);
            exe(16'h0080, 8'h00, i[3] ? 8'hc5 : 8'h00, 1'b1, tk,
                tk ? (i[4] ? 16'h0002 : 16'h0101) : 16'h0082, 8'h00,
                tk ? jbd_pkg::M_THREE : jbd_pkg::M_TWO,
                tk ? jbd_pkg::T_REL_TK
                : jbd_pkg::T_REL_NT);
        end
        $display("relative jumps done");
    endtask
    task automatic t_loop();
        put(16'h0200, jbd_pkg::OP_LOOP, 8'hfe, 8'h00);
        exe(16'h0200, 8'h01, 8'hc5, 1'b1, 1'b0, 16'h0202, 8'h00,
            jbd_pkg::M_TWO, jbd_pkg::T_LOOP_NT);
        exe(16'h0200, 8'h00, 8'h00, 1'b1, 1'b1, 16'h0200, 8'hff,
            jbd_pkg::M_THREE, jbd_pkg::T_LOOP_TK);
        exe(16'h0200, 8'h02, 8'h41, 1'b1, 1'b1, 16'h0200, 8'h01,
            jbd_pkg::M_THREE, jbd_pkg::T_LOOP_TK);
        $display("loop done");
    endtask
    task automatic t_ind();
        put(16'h0300, jbd_pkg::OP_IND, 8'h00, 8'h00);
        exe(16'h0300, 8'h33, 8'h84, 1'b1, 1'b1, ptr, 8'h33,
            jbd_pkg::M_ONE, jbd_pkg::T_IND);
        put(16'h0300, jbd_pkg::PFX_IX1, jbd_pkg::OP_IND, 8'h00);
        exe(16'h0300, 8'h33, 8'h01, 1'b1, 1'b1, ix1, 8'h33,
            jbd_pkg::M_TWO, jbd_pkg::T_IND_IX);
        put(16'h0300, jbd_pkg::PFX_IX2, jbd_pkg::OP_IND, 8'h00);
        exe(16'h0300, 8'h33, 8'h40, 1'b1, 1'b1, ix2, 8'h33,
            jbd_pkg::M_TWO, jbd_pkg::T_IND_IX);
        $display("indirect jumps done");
    endtask
    task automatic t_unknown();
        put(16'h0400, 8'h00, 8'h05, 8'h00);
        exe(16'h0400, 8'h09, 8'hff, 1'b0, 1'b0, 16'h0400, 8'h09,
            jbd_pkg::M_ONE, jbd_pkg::T_IND);
        put(16'h0400, jbd_pkg::PFX_IX1, 8'h00, 8'h00);
        exe(16'h0400, 8'h09, 8'h00, 1'b0, 1'b0, 16'h0400, 8'h09,
            jbd_pkg::M_ONE, jbd_pkg::T_IND);
        $display("foreign opcodes done");
    endtask
    initial
    begin
        #20000;
        err_total++;
        conclude();
    end
    initial
    begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk_rst();
        t_abs();
        t_rel();
        t_loop();
        t_ind();
        t_unknown();
        t_reset();
        conclude();
    end
endmodule // tb_jump_branch_decode
`default_nettype wire
